//--- src/pll_cfg_params.svh
// constants for the fractional loop configuration register bank
`ifndef PLL_CFG_PARAMS_SVH
`define PLL_CFG_PARAMS_SVH

`define ADDR_FRAC_DEN_LOW 8'h20
`define ADDR_MOD_CTRL 8'h21
`define ADDR_SYNTH_CTRL_FIRST 8'h22
`define ADDR_SYNTH_CTRL_SECOND 8'h23
`define ADDR_LF_R2 8'h24
`define ADDR_LF_C1 8'h25
`define ADDR_FIRST 8'h20
`define ADDR_LAST 8'h25

`define RST_FRAC_DEN_LOW 8'hFF
`define RST_DITHER 2'h0
`define RST_ORDER 2'h3
`define RST_CTRL_FIRST_RSVD 2'h0
`define RST_DOUBLER 1'h1
`define RST_PUMP_CURRENT 4'h4
`define RST_PUMP_DELAY 3'h2
`define RST_THIRD_ORDER 1'h1
`define RST_CTRL_SECOND_RSVD 2'h3
`define RST_LF_R2 8'h24
`define RST_LF_C1 3'h2

`define DITHER_WEAK 2'h0
`define DITHER_OFF 2'h3
`define ORDER_INTEGER 2'h0
`define ORDER_THIRD 2'h3
`define PUMP_1P6MA 4'h4
`define PUMP_6P4MA 4'h8

`define C1_BASE_PF 9'h005
`define C1_STEP_PF 9'h032

`define NV_COUNT 4'h6

`endif

//--- src/pll_cfg_pkg.sv
// types for the fractional loop configuration register bank
package pll_cfg_pkg;
   typedef enum logic [2:0] {
      LOAD_IDLE = 3'b001,
      LOAD_BUSY = 3'b010,
      LOAD_DONE = 3'b100
   } load_state_t;

   typedef enum logic [1:0] {
      MOD_INTEGER = 2'h0,
      MOD_RSVD1 = 2'h1,
      MOD_RSVD2 = 2'h2,
      MOD_THIRD = 2'h3
   } mod_order_t;
endpackage

//--- src/nv_load_if.sv
// request and answer between loader and nonvolatile reader
`timescale 1ns/1ps
interface nv_load_if;
   logic req;
   logic [3:0] index;
   logic ack;
   logic [7:0] data;
   modport bank (output req, output index, input ack, input data);
   modport reader (input req, input index, output ack, output data);
endinterface

//--- src/nv_reader.sv
// forwards start-up reads to the on-chip nonvolatile memory port
`timescale 1ns/1ps
module nv_reader (
   // clock and reset
   input wire logic clk_sys_in,
   input wire logic sys_rst_in,
   // bank side
   nv_load_if.reader load,
   // memory port
   output logic nv_rd_req_out,
   output logic [3:0] nv_rd_index_out,
   input wire logic nv_rd_valid_in,
   input wire logic [7:0] nv_rd_data_in
);
   logic pending_q;

   // one outstanding read; a new request waits for the previous answer
   always_ff @(posedge clk_sys_in) begin
      if (sys_rst_in) begin
         pending_q <= 1'b0;
      end else if (nv_rd_valid_in) begin
         pending_q <= 1'b0;
      end else if (load.req && !pending_q) begin
         pending_q <= 1'b1;
      end
   end

   always_ff @(posedge clk_sys_in) begin
      if (sys_rst_in) begin
         load.data <= 8'h00;
      end else if (nv_rd_valid_in) begin
         load.data <= nv_rd_data_in;
      end
   end

   always_ff @(posedge clk_sys_in) begin
      if (sys_rst_in) begin
         load.ack <= 1'b0;
      end else begin
         load.ack <= nv_rd_valid_in && pending_q;
      end
   end

   assign nv_rd_req_out = load.req && !pending_q;
   assign nv_rd_index_out = load.index;
endmodule

//--- src/pll_fraction_loop_config_regs.sv
// register bank for the fractional synthesizer loop settings
`timescale 1ns/1ps
`include "pll_cfg_params.svh"

// Behaviour
// (RULE1) denominator low byte, read-write, resets to FF, loaded from nonvolatile memory
// (RULE2) full 22-bit denominator joins upper six bits, middle byte, this low byte
// (RULE3) dither field bits 3:2, reset 0; 0 weak, 3 off, others reserved
// (RULE4) order field bits 1:0, reset 3; 0 integer, 3 third order
// (RULE5) reference doubler enabled by first control bit 5, reset 1
// (RULE6) pump current bits 3:0, reset 4; 4 is 1.6 mA, 8 is 6.4 mA
// (RULE7) pump delay bits 6:4, reset 2; 0 no delay
// (RULE8) second control bit 2 enables third-order filter capacitor, reset 1
// (RULE9) eight-bit R2 code, reset 24
// (RULE10) C1 code bits 2:0, reset 2; picofarads are five plus fifty per step
// (RULE11) host keeps reserved bits at defaults, including second control low bits
// (RULE12) nonvolatile-backed fields load from on-chip memory before synthesizer runs
module pll_fraction_loop_config_regs (
   // clock and reset
   input wire logic clk_sys_in,
   input wire logic sys_rst_in,
   // register port from the serial control block
   input wire logic reg_wr_in,
   input wire logic reg_rd_in,
   input wire logic [7:0] reg_addr_in,
   input wire logic [7:0] reg_wdata_in,
   output logic [7:0] reg_rdata_out,
   output logic reg_hit_out,
   // upper denominator bits held elsewhere
   input wire logic [5:0] den_upper_in,
   input wire logic [7:0] den_middle_in,
   // nonvolatile memory port
   output logic nv_rd_req_out,
   output logic [3:0] nv_rd_index_out,
   input wire logic nv_rd_valid_in,
   input wire logic [7:0] nv_rd_data_in,
   // synthesizer settings
   output logic synth_run_out,
   output logic [21:0] fractional_denominator_out,
   output logic dither_weak_out,
   output logic dither_off_out,
   output logic integer_mode_out,
   output logic third_order_mod_out,
   output logic doubler_enable_out,
   output logic [3:0] pump_current_code_out,
   output logic pump_current_valid_out,
   output logic [2:0] pump_delay_code_out,
   output logic third_order_filter_enable_out,
   output logic [7:0] filter_resistor_two_code_out,
   output logic [2:0] filter_cap_one_code_out,
   output logic [8:0] filter_cap_one_pf_out
);
   import pll_cfg_pkg::*;

   logic [7:0] den_low_q;
   logic [1:0] dither_select_q;
   logic [1:0] order_q;
   logic [1:0] ctrl_first_rsvd_q;
   logic doubler_q;
   logic [3:0] pump_current_code_q;
   logic [2:0] pump_delay_code_q;
   logic third_order_filter_enable_q;
   logic [1:0] ctrl_second_rsvd_q;
   logic [7:0] filter_resistor_two_code_q;
   logic [2:0] filter_cap_one_code_q;
   load_state_t load_state_q;
   logic [3:0] load_index_q;
   logic [7:0] rdata_q;
   logic load_wr;
   logic [7:0] load_addr;
   logic [7:0] wr_data;
   logic wr_any;
   logic [7:0] wr_addr;

   nv_load_if load ();

   nv_reader u_reader (
      .clk_sys_in(clk_sys_in),
      .sys_rst_in(sys_rst_in),
      .load(load.reader),
      .nv_rd_req_out(nv_rd_req_out),
      .nv_rd_index_out(nv_rd_index_out),
      .nv_rd_valid_in(nv_rd_valid_in),
      .nv_rd_data_in(nv_rd_data_in)
   );

   function automatic logic addr_mapped(input logic [7:0] a);
      addr_mapped = (a >= `ADDR_FIRST) && (a <= `ADDR_LAST);
   endfunction

   // start-up load walks the six bytes, one nonvolatile read per register
   always_ff @(posedge clk_sys_in) begin
      if (sys_rst_in) begin
         load_state_q <= LOAD_IDLE;
         load_index_q <= 4'h0;
      end else begin
         unique case (load_state_q)
            LOAD_IDLE: begin
               load_state_q <= LOAD_BUSY;
            end
            LOAD_BUSY: begin
               if (load.ack) begin
                  if (load_index_q == `NV_COUNT - 4'h1) begin
                     load_state_q <= LOAD_DONE; // RULE12
                  end
                  load_index_q <= load_index_q + 4'h1;
               end
            end
            LOAD_DONE: begin
               load_state_q <= LOAD_DONE;
            end
            default: begin
               load_state_q <= LOAD_IDLE;
            end
         endcase
      end
   end

   assign load.req = (load_state_q == LOAD_BUSY) && !load.ack;
   assign load.index = load_index_q;
   assign load_wr = (load_state_q == LOAD_BUSY) && load.ack; // RULE12
   assign load_addr = `ADDR_FIRST + {4'h0, load_index_q};

   // host writes are ignored until the load finishes so the image cannot overwrite them
   assign wr_any = load_wr || (reg_wr_in && load_state_q == LOAD_DONE);
   assign wr_addr = load_wr ? load_addr : reg_addr_in;
   assign wr_data = load_wr ? load.data : reg_wdata_in;

   always_ff @(posedge clk_sys_in) begin
      if (sys_rst_in) begin
         den_low_q <= `RST_FRAC_DEN_LOW; // RULE1
      end else if (wr_any && wr_addr == `ADDR_FRAC_DEN_LOW) begin
         den_low_q <= wr_data; // RULE1
      end
   end

   always_ff @(posedge clk_sys_in) begin
      if (sys_rst_in) begin
         dither_select_q <= `RST_DITHER; // RULE3
         order_q <= `RST_ORDER; // RULE4
      end else if (wr_any && wr_addr == `ADDR_MOD_CTRL) begin
         dither_select_q <= wr_data[3:2]; // RULE3
         order_q <= wr_data[1:0]; // RULE4
      end
   end

   always_ff @(posedge clk_sys_in) begin
      if (sys_rst_in) begin
         ctrl_first_rsvd_q <= `RST_CTRL_FIRST_RSVD;
         doubler_q <= `RST_DOUBLER; // RULE5
         pump_current_code_q <= `RST_PUMP_CURRENT; // RULE6
      end else if (wr_any && wr_addr == `ADDR_SYNTH_CTRL_FIRST) begin
         ctrl_first_rsvd_q <= wr_data[7:6];
         doubler_q <= wr_data[5]; // RULE5
         pump_current_code_q <= wr_data[3:0]; // RULE6
      end
   end

   always_ff @(posedge clk_sys_in) begin
      if (sys_rst_in) begin
         pump_delay_code_q <= `RST_PUMP_DELAY; // RULE7
         third_order_filter_enable_q <= `RST_THIRD_ORDER; // RULE8
         ctrl_second_rsvd_q <= `RST_CTRL_SECOND_RSVD;
      end else if (wr_any && wr_addr == `ADDR_SYNTH_CTRL_SECOND) begin
         pump_delay_code_q <= wr_data[6:4]; // RULE7
         third_order_filter_enable_q <= wr_data[2]; // RULE8
         ctrl_second_rsvd_q <= wr_data[1:0]; // RULE11
      end
   end

   always_ff @(posedge clk_sys_in) begin
      if (sys_rst_in) begin
         filter_resistor_two_code_q <= `RST_LF_R2; // RULE9
      end else if (wr_any && wr_addr == `ADDR_LF_R2) begin
         filter_resistor_two_code_q <= wr_data; // RULE9
      end
   end

   always_ff @(posedge clk_sys_in) begin
      if (sys_rst_in) begin
         filter_cap_one_code_q <= `RST_LF_C1; // RULE10
      end else if (wr_any && wr_addr == `ADDR_LF_C1) begin
         filter_cap_one_code_q <= wr_data[2:0]; // RULE10
      end
   end

   // read data registered one cycle after the strobe; unused bits read zero, reserved control bits read back as stored
   always_ff @(posedge clk_sys_in) begin
      if (sys_rst_in) begin
         rdata_q <= 8'h00;
      end else if (reg_rd_in) begin
         unique case (reg_addr_in)
            `ADDR_FRAC_DEN_LOW: rdata_q <= den_low_q;
            `ADDR_MOD_CTRL: rdata_q <= {4'h0, dither_select_q, order_q};
            `ADDR_SYNTH_CTRL_FIRST: begin
               rdata_q <= {ctrl_first_rsvd_q, doubler_q, 1'b0, pump_current_code_q};
            end
            `ADDR_SYNTH_CTRL_SECOND: begin
               rdata_q <= {1'b0, pump_delay_code_q, 1'b0, third_order_filter_enable_q,
                           ctrl_second_rsvd_q};
            end
            `ADDR_LF_R2: rdata_q <= filter_resistor_two_code_q;
            `ADDR_LF_C1: rdata_q <= {5'h00, filter_cap_one_code_q};
            default: rdata_q <= 8'h00;
         endcase
      end
   end

   assign reg_rdata_out = rdata_q;
   assign reg_hit_out = addr_mapped(reg_addr_in);
   assign synth_run_out = (load_state_q == LOAD_DONE); // RULE12

   assign fractional_denominator_out = {den_upper_in, den_middle_in, den_low_q}; // RULE2
   assign dither_weak_out = (dither_select_q == `DITHER_WEAK); // RULE3
   assign dither_off_out = (dither_select_q == `DITHER_OFF); // RULE3
   assign integer_mode_out = (order_q == MOD_INTEGER); // RULE4
   assign third_order_mod_out = (order_q == MOD_THIRD); // RULE4
   assign doubler_enable_out = doubler_q; // RULE5
   assign pump_current_code_out = pump_current_code_q;
   // unsupported codes are still stored; this flag lets the analog side ignore them
   assign pump_current_valid_out = (pump_current_code_q == `PUMP_1P6MA) ||
                                   (pump_current_code_q == `PUMP_6P4MA); // RULE6
   assign pump_delay_code_out = pump_delay_code_q; // RULE7
   assign third_order_filter_enable_out = third_order_filter_enable_q; // RULE8
   assign filter_resistor_two_code_out = filter_resistor_two_code_q; // RULE9
   assign filter_cap_one_code_out = filter_cap_one_code_q;
   assign filter_cap_one_pf_out = `C1_BASE_PF +
                                  9'(`C1_STEP_PF * {6'h00, filter_cap_one_code_q}); // RULE10
endmodule

//--- tb/pll_cfg_asserts.sv
// concurrent checks on the loop configuration register bank ports
`timescale 1ns/1ps
module pll_cfg_asserts (
   input wire logic clk_sys_in, sys_rst_in, reg_wr_in,
   input wire logic [7:0] reg_addr_in, reg_wdata_in,
   input wire logic [5:0] den_upper_in,
   input wire logic [7:0] den_middle_in, filter_resistor_two_code_out,
   input wire logic nv_rd_req_out, nv_rd_valid_in, synth_run_out,
   input wire logic [3:0] nv_rd_index_out, pump_current_code_out,
   input wire logic [21:0] fractional_denominator_out,
   input wire logic dither_weak_out, dither_off_out, integer_mode_out, third_order_mod_out,
   input wire logic doubler_enable_out, pump_current_valid_out, third_order_filter_enable_out,
   input wire logic [2:0] pump_delay_code_out, filter_cap_one_code_out,
   input wire logic [8:0] filter_cap_one_pf_out
);
   default clocking @(posedge clk_sys_in); endclocking
   default disable iff (sys_rst_in);
   logic [7:0] wd_q;
   logic ok;
   assign ok = reg_wr_in && synth_run_out;
   always_ff @(posedge clk_sys_in) wd_q <= reg_wdata_in;
   AST_DEN_JOIN: assert property (
      fractional_denominator_out[21:8] == {den_upper_in, den_middle_in}) else $error("den join");
   AST_DITHER: assert property (ok && reg_addr_in == 8'h21 |=>
      dither_weak_out == (wd_q[3:2] == 2'h0) && dither_off_out == (wd_q[3:2] == 2'h3))
      else $error("dither decode");
   AST_ORDER: assert property (ok && reg_addr_in == 8'h21 |=>
      integer_mode_out == (wd_q[1:0] == 2'h0) && third_order_mod_out == (wd_q[1:0] == 2'h3))
      else $error("order decode");
   AST_PUMP: assert property (ok && reg_addr_in == 8'h22 |=> doubler_enable_out == wd_q[5] &&
      pump_current_code_out == wd_q[3:0] && pump_current_valid_out ==
      (wd_q[3:0] == 4'h4 || wd_q[3:0] == 4'h8)) else $error("first control");
   AST_SECOND: assert property (ok && reg_addr_in == 8'h23 |=>
      pump_delay_code_out == wd_q[6:4] && third_order_filter_enable_out == wd_q[2])
      else $error("second control");
   AST_R2: assert property (ok && reg_addr_in == 8'h24 |=>
      filter_resistor_two_code_out == wd_q) else $error("r2 code");
   AST_PF: assert property (filter_cap_one_pf_out ==
      9'h005 + 9'h032 * {6'h00, filter_cap_one_code_out}) else $error("c1 picofarads");
   AST_RESET: assert property ($fell(sys_rst_in) |-> !synth_run_out && doubler_enable_out &&
      fractional_denominator_out[7:0] == 8'hFF && filter_cap_one_code_out == 3'h2)
      else $error("reset values");
   // request is a single-cycle pulse; the reader keeps one read outstanding
   AST_NV_HOLD: assert property (nv_rd_req_out |=>
      !nv_rd_req_out && $stable(nv_rd_index_out)) else $error("load request repeated");
   // a load write lands the edge after the ack, which follows the memory answer
   AST_WR_BLOCKED: assert property (!synth_run_out && reg_wr_in && reg_addr_in == 8'h24 &&
      !$past(nv_rd_valid_in) |=> $stable(filter_resistor_two_code_out))
      else $error("write before load");
endmodule
bind pll_fraction_loop_config_regs pll_cfg_asserts u_chk (.*);

//--- tb/nv_mem_model.sv
// nonvolatile memory stand-in answering start-up reads
`timescale 1ns/1ps
module nv_mem_model (
   input wire logic clk_sys_in,
   input wire logic sys_rst_in,
   input wire logic req_in,
   input wire logic [3:0] index_in,
   output logic valid_out,
   output logic [7:0] data_out
);
   logic [7:0] image [6] = '{8'hA5, 8'h0C, 8'h08, 8'h73, 8'h40, 8'h05};
   logic busy = 1'b0;
   logic [2:0] wait_q = 3'h0;
   logic [2:0] gap_q = 3'h0;
   initial valid_out = 1'b0;
   initial data_out = 8'h5A;
   always @(posedge clk_sys_in) begin
      valid_out <= 1'b0;
      data_out <= ~data_out; // no stale byte outside an answer
      if (sys_rst_in) begin
         busy <= 1'b0;
         gap_q <= 3'h0;
      end else if (busy && wait_q != 3'h0) begin
         wait_q <= wait_q - 3'h1;
      end else if (busy) begin
         valid_out <= 1'b1;
         data_out <= image[index_in];
         busy <= 1'b0;
         gap_q <= 3'h2; // two idle cycles after each answer before a new request is taken
      end else if (gap_q != 3'h0) begin
         gap_q <= gap_q - 3'h1;
      end else if (req_in) begin
         busy <= 1'b1;
         wait_q <= index_in[0] ? 3'h4 : 3'h0; // odd bytes answer slowly
      end
   end
endmodule

//--- tb/pll_fraction_loop_config_regs_bench.sv
// self-checking bench for the loop configuration register bank
`timescale 1ns/1ps
module pll_fraction_loop_config_regs_bench;
   logic clk_sys_in = 0, sys_rst_in = 1, reg_wr_in = 0, reg_rd_in = 0;
   logic [7:0] reg_addr_in = 8'h00, reg_wdata_in = 8'h00, reg_rdata_out, rv;
   logic [5:0] den_upper_in = 6'h2A;
   logic [7:0] den_middle_in = 8'hC3, nv_rd_data_in, filter_resistor_two_code_out;
   logic nv_rd_req_out, nv_rd_valid_in, reg_hit_out, synth_run_out;
   logic [3:0] nv_rd_index_out, pump_current_code_out;
   logic [21:0] fractional_denominator_out;
   logic dither_weak_out, dither_off_out, integer_mode_out, third_order_mod_out;
   logic doubler_enable_out, pump_current_valid_out, third_order_filter_enable_out;
   logic [2:0] pump_delay_code_out, filter_cap_one_code_out;
   logic [8:0] filter_cap_one_pf_out;
   logic [7:0] img [6] = '{8'hA5, 8'h0C, 8'h08, 8'h73, 8'h40, 8'h05};
   int n_fail = 0, n_tests = 0;
   pll_fraction_loop_config_regs i_dut (.*);
   nv_mem_model i_nv (.clk_sys_in, .sys_rst_in, .req_in(nv_rd_req_out),
      .index_in(nv_rd_index_out), .valid_out(nv_rd_valid_in), .data_out(nv_rd_data_in));
   initial forever #2 clk_sys_in = ~clk_sys_in;
   task automatic chk(string nm, logic [21:0] seen, logic [21:0] exp);
      n_tests++;
      if (seen !== exp) begin
         n_fail++;
         $display("wrong value %s expected %h seen %h", nm, exp, seen);
      end
   endtask
   // leaves the strobe up so the next access follows back to back
   task automatic wr(logic [7:0] a, logic [7:0] d);
      @(posedge clk_sys_in) #1;
      reg_rd_in = 0;
      reg_wr_in = 1;
      reg_addr_in = a;
      reg_wdata_in = d;
   endtask
   task automatic rd(logic [7:0] a);
      @(posedge clk_sys_in) #1;
      reg_wr_in = 0;
      reg_rd_in = 1;
      reg_addr_in = a;
      @(posedge clk_sys_in) #1;
      reg_rd_in = 0;
      rv = reg_rdata_out;
   endtask
   task automatic t_load;
      wr(8'h24, 8'h77);
      rd(8'h25);
      chk("early c1", rv, 8'h02);
      chk("early doubler", doubler_enable_out, 1);
      for (int i = 0; i < 300 && synth_run_out !== 1'b1; i++) @(posedge clk_sys_in);
      chk("load done", synth_run_out, 1'b1);
      chk("nv idle", nv_rd_req_out, 1'b0);
      for (int i = 0; i < 6; i++) begin
         rd(8'h20 + i[7:0]);
         chk("loaded byte", rv, img[i]);
      end
      chk("denominator", fractional_denominator_out, 22'h2AC3A5);
      chk("c1 pf", filter_cap_one_pf_out, 9'h0FF);
      $display("load test done");
   endtask
   task automatic t_mod;
      for (int i = 0; i < 16; i++) begin
         wr(8'h21, i[7:0]);
         rd(8'h21);
         chk("mod ctrl", rv, i);
         chk("weak", dither_weak_out, i[3:2] == 0);
         chk("off", dither_off_out, i[3:2] == 3);
         chk("integer", integer_mode_out, i[1:0] == 0);
         chk("third", third_order_mod_out, i[1:0] == 3);
      end
      $display("modulator test done");
   endtask
   task automatic t_pump;
      // host keeps reserved bits at zero and writes listed pump codes only
      logic [7:0] v [3] = '{8'h24, 8'h08, 8'h28};
      for (int i = 0; i < 3; i++) begin
         wr(8'h22, v[i]);
         rd(8'h22);
         chk("ctrl first", rv, v[i] & 8'hEF);
         chk("pump ok", pump_current_valid_out, v[i][3:0] == 4 || v[i][3:0] == 8);
         chk("doubler", doubler_enable_out, v[i][5]);
         chk("pump code", pump_current_code_out, v[i][3:0]);
      end
      $display("pump test done");
   endtask
   task automatic t_filter;
      for (int c = 0; c < 8; c++) begin
         wr(8'h23, {1'b0, c[2:0], 1'b0, c[0], 2'h3});
         wr(8'h24, {c[2:0], 5'h01});
         wr(8'h25, {5'h00, c[2:0]});
         rd(8'h23);
         chk("ctrl second", rv, {1'b0, c[2:0], 1'b0, c[0], 2'h3});
         chk("c3 enable", third_order_filter_enable_out, c[0]);
         chk("delay", pump_delay_code_out, c);
         rd(8'h25);
         chk("c1 code", rv, c);
         chk("c1 pf", filter_cap_one_pf_out, 5 + 50 * c);
         chk("c1 out", filter_cap_one_code_out, c);
         chk("r2 code", filter_resistor_two_code_out, {c[2:0], 5'h01});
      end
      $display("filter test done");
   endtask
   // mid-run reset: defaults while held, then the image is loaded again
   task automatic t_reset;
      @(posedge clk_sys_in) #1;
      sys_rst_in = 1;
      repeat (2) @(posedge clk_sys_in);
      #1 chk("rst den", fractional_denominator_out[7:0], 8'hFF);
      chk("rst dither", {dither_weak_out, dither_off_out}, 2'b10);
      chk("rst order", {integer_mode_out, third_order_mod_out}, 2'b01);
      chk("rst doubler", doubler_enable_out, 1'b1);
      chk("rst pump", pump_current_code_out, 4'h4);
      chk("rst delay", pump_delay_code_out, 3'h2);
      chk("rst c3", third_order_filter_enable_out, 1'b1);
      chk("rst r2", filter_resistor_two_code_out, 8'h24);
      chk("rst c1 pf", filter_cap_one_pf_out, 9'h069);
      chk("rst run", {synth_run_out, nv_rd_req_out}, 2'b00);
      sys_rst_in = 0;
      for (int i = 0; i < 300 && synth_run_out !== 1'b1; i++) @(posedge clk_sys_in);
      chk("reload run", synth_run_out, 1'b1);
      chk("reload r2", filter_resistor_two_code_out, 8'h40);
      chk("reload c1", filter_cap_one_code_out, 3'h5);
      chk("reload pump", pump_current_code_out, 4'h8);
      $display("reset test done");
   endtask
   task automatic t_unmapped;
      wr(8'h1F, 8'h00);
      rd(8'h26);
      chk("unmapped", {rv, reg_hit_out}, 9'h000);
      rd(8'h20);
      chk("low byte kept", rv, 8'hA5);
      chk("hit", reg_hit_out, 1'b1);
      den_upper_in = 6'h15;
      #1 chk("denominator", fractional_denominator_out, 22'h15C3A5);
      $display("unmapped test done");
   endtask
   task automatic give_verdict;
      $display("comparisons %0d mismatches %0d", n_tests, n_fail);
      if (n_fail == 0 && n_tests > 0) $display("ALL CHECKS OK");
      else $display("CHECKS NOT OK");
      $finish;
   endtask
   initial begin
      #20000;
      n_fail++;
      give_verdict();
   end
   initial begin
      repeat (20) @(posedge clk_sys_in);
      #1 sys_rst_in = 0;
      t_load();
      t_mod();
      t_pump();
      t_filter();
      t_reset();
      t_unmapped();
      give_verdict();
   end
endmodule
